// file: hw/pll_clock_control_pkg.sv
package pll_clock_control_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] ADDR_CLOCK_CONTROL_ZERO = 8'h00;
    localparam logic [7:0] ADDR_CLOCK_CONTROL_ONE = 8'h01;
    localparam logic [7:0] RESET_CLOCK_CONTROL_ZERO = 8'h00;
    localparam logic [7:0] RESET_CLOCK_CONTROL_ONE = 8'h2a;

    // ****************************************
    // Field positions in registers zero and one
    // ****************************************
    localparam int POS_PLL_REFERENCE_SELECT = 6;
    localparam int POS_CRYSTAL_OSC_SETTING = 4;
    localparam int POS_SOFT_RESET = 3;
    localparam int POS_MASTER_CLOCK_RATIO = 1;
    localparam int POS_MASTER_POWER_UP = 0;
    localparam int POS_CONVERTER_CLOCK_SOURCE = 0;
    localparam int POS_PLL_LOCK_INDICATOR = 2;

    // ****************************************
    // Field encodings
    // ****************************************
    typedef enum logic [1:0]
    {
        PLL_REF_MASTER_OR_CRYSTAL = 2'h0,
        PLL_REF_FRAME_CLOCK = 2'h1,
        PLL_REF_RESERVED_2 = 2'h2,
        PLL_REF_RESERVED_3 = 2'h3
    } pll_reference_t;

    localparam logic [1:0] CRYSTAL_RUNNING = 2'h0;
    localparam logic [1:0] CRYSTAL_OUTPUT_OFF = 2'h3;

    // Ratio multipliers for 32 to 48 kHz sample rates
    localparam logic [9:0] RATIO_CODE_0 = 10'h100;
    localparam logic [9:0] RATIO_CODE_1 = 10'h180;
    localparam logic [9:0] RATIO_CODE_2 = 10'h200;
    localparam logic [9:0] RATIO_CODE_3 = 10'h300;

endpackage

// file: hw/clock_field_decoder.sv
`timescale 1ns/1ps
`default_nettype none

module clock_field_decoder
(
    input wire logic [7:0] control_zero_in,
    input wire logic converter_clock_source_in,
    output logic pll_from_frame_clock_out,
    output logic pll_reference_valid_out,
    output logic crystal_output_enable_out,
    output logic crystal_setting_valid_out,
    output logic [9:0] master_clock_multiple_out,
    output logic master_clock_direct_out
);

    logic [1:0] reference;
    logic [1:0] crystal;
    logic [1:0] ratio;

    assign reference = control_zero_in[pll_clock_control_pkg::POS_PLL_REFERENCE_SELECT +: 2];
    assign crystal = control_zero_in[pll_clock_control_pkg::POS_CRYSTAL_OSC_SETTING +: 2];
    assign ratio = control_zero_in[pll_clock_control_pkg::POS_MASTER_CLOCK_RATIO +: 2];

    always_comb
    begin
        // Reserved codes flagged invalid; PLL stays on master input
        pll_from_frame_clock_out = (reference == pll_clock_control_pkg::PLL_REF_FRAME_CLOCK);
        pll_reference_valid_out = (reference == pll_clock_control_pkg::PLL_REF_MASTER_OR_CRYSTAL)
            || (reference == pll_clock_control_pkg::PLL_REF_FRAME_CLOCK);
        // Reserved crystal codes keep oscillator running, the safer state
        crystal_output_enable_out = (crystal != pll_clock_control_pkg::CRYSTAL_OUTPUT_OFF);
        crystal_setting_valid_out = (crystal == pll_clock_control_pkg::CRYSTAL_RUNNING)
            || (crystal == pll_clock_control_pkg::CRYSTAL_OUTPUT_OFF);
        unique case (ratio)
            2'h0: master_clock_multiple_out = pll_clock_control_pkg::RATIO_CODE_0;
            2'h1: master_clock_multiple_out = pll_clock_control_pkg::RATIO_CODE_1;
            2'h2: master_clock_multiple_out = pll_clock_control_pkg::RATIO_CODE_2;
            2'h3: master_clock_multiple_out = pll_clock_control_pkg::RATIO_CODE_3;
        endcase
        master_clock_direct_out = converter_clock_source_in;
    end

endmodule // clock_field_decoder

`default_nettype wire

// file: hw/pll_clock_control_reg.sv
`timescale 1ns/1ps
`default_nettype none

module pll_clock_control_reg
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic write_strobe_in,
    input wire logic read_strobe_in,
    input wire logic [7:0] address_in,
    input wire logic [7:0] write_data_in,
    input wire logic pll_locked_in,
    output logic [7:0] read_data_out,
    output logic read_valid_out,
    output logic [7:0] control_zero_out,
    output logic [1:0] pll_reference_select_out,
    output logic pll_from_frame_clock_out,
    output logic [1:0] crystal_osc_setting_out,
    output logic crystal_output_enable_out,
    output logic [1:0] master_clock_ratio_out,
    output logic [9:0] master_clock_multiple_out,
    output logic master_clock_direct_out,
    output logic master_power_up_out,
    output logic core_reset_n_out,
    output logic config_undefined_out,
    output logic powered_before_config_out
);

    // ****************************************
    // Register state
    // ****************************************
    logic [7:0] control_zero;
    logic [7:0] next_control_zero;
    logic [7:0] control_one;
    logic [7:0] next_control_one;
    logic [7:0] read_data;
    logic [7:0] next_read_data;
    logic read_valid;
    logic next_read_valid;
    logic first_write_seen;
    logic next_first_write_seen;
    logic first_write_good;
    logic next_first_write_good;

    logic hit_zero;
    logic hit_one;
    logic soft_reset;
    logic frame_ref;
    logic ref_valid;
    logic xtal_en;
    logic xtal_valid;
    logic [9:0] multiple;
    logic direct;

    assign hit_zero = (address_in == pll_clock_control_pkg::ADDR_CLOCK_CONTROL_ZERO);
    assign hit_one = (address_in == pll_clock_control_pkg::ADDR_CLOCK_CONTROL_ONE);
    assign soft_reset = control_zero[pll_clock_control_pkg::POS_SOFT_RESET];

    clock_field_decoder decoder
    (
        .control_zero_in(control_zero),
        .converter_clock_source_in(control_one[pll_clock_control_pkg::POS_CONVERTER_CLOCK_SOURCE]),
        .pll_from_frame_clock_out(frame_ref),
        .pll_reference_valid_out(ref_valid),
        .crystal_output_enable_out(xtal_en),
        .crystal_setting_valid_out(xtal_valid),
        .master_clock_multiple_out(multiple),
        .master_clock_direct_out(direct)
    );

    // ****************************************
    // Register writes and reads
    // ****************************************
    always_comb
    begin
        next_control_zero = control_zero;
        next_control_one = control_one;
        next_read_data = read_data;
        next_read_valid = 1'b0;
        next_first_write_seen = first_write_seen;
        next_first_write_good = first_write_good;
        // Soft reset never touches these two; the control port stays alive
        if (write_strobe_in && hit_zero)
        begin
            next_control_zero = write_data_in;
        end
        if (write_strobe_in && hit_one)
        begin
            // Lock indicator is read only and never stored
            next_control_one = write_data_in;
            next_control_one[pll_clock_control_pkg::POS_PLL_LOCK_INDICATOR] = 1'b0;
        end
        if (write_strobe_in && !first_write_seen)
        begin
            next_first_write_seen = 1'b1;
            next_first_write_good = hit_zero && write_data_in[pll_clock_control_pkg::POS_MASTER_POWER_UP];
        end
        if (read_strobe_in)
        begin
            next_read_valid = 1'b1;
            if (hit_zero)
            begin
                next_read_data = control_zero;
            end
            else if (hit_one)
            begin
                next_read_data = control_one;
                next_read_data[pll_clock_control_pkg::POS_PLL_LOCK_INDICATOR] = pll_locked_in;
            end
            else
            begin
                // Unmapped here; other registers belong to other blocks
                next_read_data = 8'h00;
            end
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            control_zero <= pll_clock_control_pkg::RESET_CLOCK_CONTROL_ZERO;
            control_one <= pll_clock_control_pkg::RESET_CLOCK_CONTROL_ONE;
            read_data <= 8'h00;
            read_valid <= 1'b0;
            first_write_seen <= 1'b0;
            first_write_good <= 1'b0;
        end
        else
        begin
            control_zero <= next_control_zero;
            control_one <= next_control_one;
            read_data <= next_read_data;
            read_valid <= next_read_valid;
            first_write_seen <= next_first_write_seen;
            first_write_good <= next_first_write_good;
        end
    end

    // ****************************************
    // Registered control outputs
    // ****************************************
    logic [7:0] next_zero_out;
    logic [1:0] next_ref_out;
    logic next_frame_out;
    logic [1:0] next_xtal_out;
    logic next_xtal_en_out;
    logic [1:0] next_ratio_out;
    logic [9:0] next_multiple_out;
    logic next_direct_out;
    logic next_power_out;
    logic next_core_reset_n;
    logic next_undefined;

    always_comb
    begin
        next_zero_out = control_zero;
        next_ref_out = control_zero[pll_clock_control_pkg::POS_PLL_REFERENCE_SELECT +: 2];
        next_frame_out = frame_ref;
        next_xtal_out = control_zero[pll_clock_control_pkg::POS_CRYSTAL_OSC_SETTING +: 2];
        next_xtal_en_out = xtal_en;
        next_ratio_out = control_zero[pll_clock_control_pkg::POS_MASTER_CLOCK_RATIO +: 2];
        next_multiple_out = multiple;
        next_direct_out = direct;
        next_power_out = control_zero[pll_clock_control_pkg::POS_MASTER_POWER_UP];
        next_core_reset_n = !soft_reset;
        next_undefined = !ref_valid || !xtal_valid;
    end

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            control_zero_out <= 8'h00;
            pll_reference_select_out <= 2'h0;
            pll_from_frame_clock_out <= 1'b0;
            crystal_osc_setting_out <= 2'h0;
            crystal_output_enable_out <= 1'b1;
            master_clock_ratio_out <= 2'h0;
            master_clock_multiple_out <= pll_clock_control_pkg::RATIO_CODE_0;
            master_clock_direct_out <= 1'b0;
            master_power_up_out <= 1'b0;
            core_reset_n_out <= 1'b0;
            config_undefined_out <= 1'b0;
        end
        else
        begin
            control_zero_out <= next_zero_out;
            pll_reference_select_out <= next_ref_out;
            pll_from_frame_clock_out <= next_frame_out;
            crystal_osc_setting_out <= next_xtal_out;
            crystal_output_enable_out <= next_xtal_en_out;
            master_clock_ratio_out <= next_ratio_out;
            master_clock_multiple_out <= next_multiple_out;
            master_clock_direct_out <= next_direct_out;
            master_power_up_out <= next_power_out;
            core_reset_n_out <= next_core_reset_n;
            config_undefined_out <= next_undefined;
        end
    end

    assign read_data_out = read_data;
    assign read_valid_out = read_valid;
    assign powered_before_config_out = first_write_good;

endmodule // pll_clock_control_reg

`default_nettype wire

// file: sim/pll_clock_control_reg_sva.sv
`timescale 1ns/1ps
`default_nettype none

module pll_clock_control_reg_sva
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic write_strobe_in,
    input wire logic read_strobe_in,
    input wire logic [7:0] address_in,
    input wire logic [7:0] write_data_in,
    input wire logic [7:0] read_data_out,
    input wire logic read_valid_out,
    input wire logic [7:0] control_zero_out,
    input wire logic [1:0] pll_reference_select_out,
    input wire logic pll_from_frame_clock_out,
    input wire logic [1:0] crystal_osc_setting_out,
    input wire logic crystal_output_enable_out,
    input wire logic [1:0] master_clock_ratio_out,
    input wire logic [9:0] master_clock_multiple_out,
    input wire logic master_clock_direct_out,
    input wire logic master_power_up_out,
    input wire logic core_reset_n_out,
    input wire logic config_undefined_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    // ****************************************
    // Register copies and decodes
    // ****************************************
    a_write_copy: assert property (
        write_strobe_in && address_in == 8'h00 |-> ##2 control_zero_out == $past(write_data_in, 2))
        else $error("Register zero copy wrong");
    a_hold_contents: assert property (
        !(write_strobe_in && address_in == 8'h00) |-> ##2 $stable(control_zero_out))
        else $error("Register zero changed without a write");
    a_read_latency: assert property (
        read_strobe_in && address_in == 8'h00 |=> read_valid_out && read_data_out == control_zero_out)
        else $error("Register zero read wrong");
    a_pll_ref_decode: assert property (
        pll_reference_select_out == control_zero_out[7:6]
        && pll_from_frame_clock_out == (control_zero_out[7:6] == 2'h1))
        else $error("Reference select decode wrong");
    a_crystal_decode: assert property (
        crystal_osc_setting_out == control_zero_out[5:4]
        && crystal_output_enable_out == (control_zero_out[5:4] != 2'h3))
        else $error("Crystal decode wrong");
    // Core reset lags the release by one edge, so skip that edge
    a_soft_reset_core: assert property (
        $past(rst_n_in) |-> core_reset_n_out == !control_zero_out[3])
        else $error("Core reset does not follow soft reset bit");
    a_ratio_decode: assert property (
        master_clock_ratio_out == control_zero_out[2:1] && master_clock_multiple_out ==
        (control_zero_out[2] ? (control_zero_out[1] ? 10'h300 : 10'h200) : (control_zero_out[1] ? 10'h180 : 10'h100)))
        else $error("Ratio decode wrong");
    a_power_config: assert property (
        master_power_up_out == control_zero_out[0] && config_undefined_out ==
        (control_zero_out[7] || control_zero_out[5:4] == 2'h1 || control_zero_out[5:4] == 2'h2))
        else $error("Power or undefined flag wrong");
    a_direct_bit: assert property (
        write_strobe_in && address_in == 8'h01 |->
        ##2 {7'h00, master_clock_direct_out} == ($past(write_data_in, 2) & 8'h01))
        else $error("Clock source bit wrong");
endmodule // pll_clock_control_reg_sva

bind pll_clock_control_reg pll_clock_control_reg_sva chk (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .write_strobe_in(write_strobe_in), .read_strobe_in(read_strobe_in), .address_in(address_in),
    .write_data_in(write_data_in), .read_data_out(read_data_out), .read_valid_out(read_valid_out),
    .control_zero_out(control_zero_out), .pll_reference_select_out(pll_reference_select_out),
    .pll_from_frame_clock_out(pll_from_frame_clock_out), .crystal_osc_setting_out(crystal_osc_setting_out),
    .crystal_output_enable_out(crystal_output_enable_out), .master_clock_ratio_out(master_clock_ratio_out),
    .master_clock_multiple_out(master_clock_multiple_out), .master_clock_direct_out(master_clock_direct_out),
    .master_power_up_out(master_power_up_out), .core_reset_n_out(core_reset_n_out),
    .config_undefined_out(config_undefined_out));

`default_nettype wire

// file: sim/pll_clock_control_reg_test.sv
`timescale 1ns/1ps
`default_nettype none

module pll_clock_control_reg_test;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0, write_strobe_in = 1'b0, read_strobe_in = 1'b0, pll_locked_in = 1'b0;
    logic [7:0] address_in = 8'h00, write_data_in = 8'h00, read_data_out, control_zero_out, rexp;
    logic [1:0] pll_reference_select_out, crystal_osc_setting_out, master_clock_ratio_out;
    logic [9:0] master_clock_multiple_out;
    logic read_valid_out, pll_from_frame_clock_out, crystal_output_enable_out, master_clock_direct_out;
    logic master_power_up_out, core_reset_n_out, config_undefined_out, powered_before_config_out;
    logic [7:0] regm [2] = '{8'h00, 8'h2a};
    logic first_ok = 1'b0;
    int writes = 0;
    int n_fail = 0;
    int samples_checked = 0;
    int mults [4] = '{256, 384, 512, 768};

    always #2 clk_in = ~clk_in;

    pll_clock_control_reg dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .write_strobe_in(write_strobe_in),
        .read_strobe_in(read_strobe_in), .address_in(address_in), .write_data_in(write_data_in),
        .pll_locked_in(pll_locked_in), .read_data_out(read_data_out), .read_valid_out(read_valid_out),
        .control_zero_out(control_zero_out), .pll_reference_select_out(pll_reference_select_out),
        .pll_from_frame_clock_out(pll_from_frame_clock_out), .crystal_osc_setting_out(crystal_osc_setting_out),
        .crystal_output_enable_out(crystal_output_enable_out), .master_clock_ratio_out(master_clock_ratio_out),
        .master_clock_multiple_out(master_clock_multiple_out), .master_clock_direct_out(master_clock_direct_out),
        .master_power_up_out(master_power_up_out), .core_reset_n_out(core_reset_n_out),
        .config_undefined_out(config_undefined_out), .powered_before_config_out(powered_before_config_out));

    // ****************************************
    // Checks against the model
    // ****************************************
    task cmp(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task check_outputs();
        logic [7:0] e;
        e = regm[0];
        cmp(control_zero_out, e);
        cmp({pll_reference_select_out, pll_from_frame_clock_out}, {e[7:6], e[7:6] == 2'h1});
        cmp({crystal_osc_setting_out, crystal_output_enable_out}, {e[5:4], e[5:4] != 2'h3});
        cmp(core_reset_n_out, !e[3]);
        cmp({master_clock_ratio_out, master_clock_multiple_out}, {e[2:1], 10'(mults[e[2:1]])});
        cmp(master_power_up_out, e[0]);
        cmp(config_undefined_out, e[7] || e[5:4] == 2'h1 || e[5:4] == 2'h2);
        cmp(master_clock_direct_out, regm[1][0]);
        cmp(powered_before_config_out, first_ok);
    endtask

    // Two edges per access so derived outputs have settled before checking
    task bus(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
        write_strobe_in = w;
        read_strobe_in = r;
        address_in = a;
        write_data_in = d;
        rexp = (a == 8'h00) ? regm[0] : (a == 8'h01) ? (regm[1] | {5'h00, pll_locked_in, 2'h0}) : 8'h00;
        @(posedge clk_in);
        #1;
        write_strobe_in = 1'b0;
        read_strobe_in = 1'b0;
        if (w && writes == 0)
            first_ok = (a == 8'h00) && d[0];
        if (w)
            writes++;
        if (w && a < 8'h02)
            regm[a[0]] = (a == 8'h01) ? (d & 8'hfb) : d;
        if (r)
            cmp({read_valid_out, read_data_out}, {1'b1, rexp});
        @(posedge clk_in);
        #1;
        cmp(read_valid_out, 1'b0);
        check_outputs();
    endtask

    task stop_test();
        $display("Comparisons %0d, mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        void'($urandom(32'h3e15));
        repeat (12) @(posedge clk_in);
        #1;
        rst_n_in = 1'b1;
        repeat (2) @(posedge clk_in);
        #1;
        check_outputs();
        bus(1'b0, 1'b1, 8'h00, 8'h00);
        bus(1'b0, 1'b1, 8'h01, 8'h00);
        bus(1'b0, 1'b1, 8'h05, 8'h00);
        bus(1'b1, 1'b0, 8'h00, 8'h01);
        for (int i = 0; i < 256; i++)
        begin
            bus(1'b1, 1'b1, 8'h00, 8'(i));
            if (i[3])
            begin
                bus(1'b1, 1'b0, 8'h01, 8'($urandom));
                bus(1'b0, 1'b1, 8'h01, 8'h00);
            end
        end
        for (int i = 0; i < 200; i++)
        begin
            pll_locked_in = 1'($urandom);
            @(posedge clk_in);
            #1;
            bus(1'($urandom), 1'($urandom), ($urandom_range(0, 3) == 3) ? 8'($urandom) : 8'($urandom_range(0, 2)),
                8'($urandom));
        end
        stop_test();
    end
endmodule // pll_clock_control_reg_test

`default_nettype wire
